// ===== dsfm_pkg.sv
/*
 * Package of the drain-source fault monitor: register map, field layouts,
 * reset values, timing tables and the packed carriers of the top module.
 * Assumes a single 100 MHz core clock and a plain strobe register port.
 */
`default_nettype none

package dsfm_pkg;

  localparam int NUM_HB = 8;          // half-bridges
  localparam int NUM_FET = 16;        // 0..7 high side, 8..15 low side
  localparam int CLK_MHZ = 100;       // core clock rate
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BLANK_W = 11;        // holds the longest blank count
  localparam int FILT_W = 11;         // holds twice the longest filter

  // register byte addresses
  localparam logic [7:0] ADDR_GCTRL = 8'h00;  // general_control_two
  localparam logic [7:0] ADDR_THR = 8'h04;    // vds_threshold_cfg_a
  localparam logic [7:0] ADDR_REF = 8'h08;    // vds_threshold_cfg_b
  localparam logic [7:0] ADDR_BLANK = 8'h0C;  // blank time per pair
  localparam logic [7:0] ADDR_PAIR = 8'h10;   // timing pair per bridge
  localparam logic [7:0] ADDR_STAT = 8'h14;   // vds_fault_status
  localparam logic [7:0] ADDR_GSTAT = 8'h18;  // global status byte

  // general_control_two and global status field positions
  localparam int GC_PASSIVE_BIT = 0;
  localparam int GC_FILT_LSB = 1;
  localparam int GC_DIS_LSB = 3;
  localparam int GSTAT_GLOBAL_VDS_ERROR_BIT = 0;

  // reset values
  localparam logic [1:0] FILT_RST = 2'h0;
  localparam logic [4:0] DIS_RST = 5'h0;
  localparam logic PASSIVE_RST = 1'b0;
  localparam logic [23:0] THR_RST = {8{3'h1}};
  localparam logic [7:0] REF_RST = 8'h00;
  localparam logic [11:0] BLANK_RST = {4{3'h4}};
  localparam logic [15:0] PAIR_RST = 16'h0000;

  // blank and filter times in ns, indexed by their codes
  localparam int BLANK_NS [8] = '{625, 1000, 1250, 1500, 2000, 3000,
                                  4000, 16000};
  localparam int FILT_NS [4] = '{500, 1000, 2000, 3000};

  // least time to cycles, rounded up, never below one
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } dsfm_bus_req_t;

  // settings handed to the analog comparator path
  typedef struct packed {
    logic [NUM_HB-1:0][2:0] threshold;  // hb_vds_threshold
    logic [NUM_HB-1:0] drain_ref_sel;   // hb_drain_ref_sel
  } dsfm_cmp_cfg_t;

  // gate path towards the drivers
  typedef struct packed {
    logic [NUM_HB-1:0] hs_on;
    logic [NUM_HB-1:0] ls_on;
    logic [NUM_HB-1:0] static_discharge;
    logic [4:0] discharge_current;
  } dsfm_gate_t;

endpackage

`default_nettype wire

// ===== dsfm_monitor.sv
/*
 * Drain-source overvoltage monitor for eight half-bridges: blank timing,
 * comparator filtering, fault latch-off, status and a strobe register port.
 * Assumes comparator results and the enable pin arrive asynchronously and
 * that gate-on requests come from logic on clk_in.
 */
// Contract
// - monitor switched-on FETs only while enabled and bridge not passive
// - a confirmed fault latches its half-bridge off
// - drain reference select clear: high side compares drain sense to node
// - drain reference select set: high side uses shunt input one instead
// - low side short to supply seen between node and low source ref
// - 3-bit threshold per bridge, 150 mV to 2 V, reset code 001
// - fault only after blank expiry and comparator high beyond filter time
// - short present during blank trips after blank plus two filter times
// - 2-bit filter time 0.5, 1, 2, 3 us, default 0.5 us
// - latched-off bridge discharges with static discharge current
// - fault sets the affected FET's bit in fault status
// - fault sets the global vds error flag
// - bridge stays off until controller clears its fault status
// - blank time starts at each turn-on, 625 ns to 16 us, default 2 us
// - static turn-on from high impedance starts blank at command decode
// - 2-bit pair select per bridge picks one of four blank times
`default_nettype none

module dsfm_monitor (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic [dsfm_pkg::NUM_HB-1:0] hs_on_req_in,
  input wire logic [dsfm_pkg::NUM_HB-1:0] ls_on_req_in,
  input wire logic [dsfm_pkg::NUM_HB-1:0] hs_over_in,
  input wire logic [dsfm_pkg::NUM_HB-1:0] ls_over_in,
  input wire dsfm_pkg::dsfm_bus_req_t bus_in,
  output logic [dsfm_pkg::DATA_W-1:0] bus_rdata_out,
  output var dsfm_pkg::dsfm_cmp_cfg_t cmp_cfg_out,
  output var dsfm_pkg::dsfm_gate_t gate_out,
  output logic global_vds_error_out
);
  import dsfm_pkg::*;

  typedef struct packed {
    logic bridge_passive_sel;
    logic [1:0] vds_filter_time;
    logic [4:0] static_discharge_current_cfg;
    logic [23:0] thr;
    logic [7:0] drain_ref;
    logic [11:0] blank_time_sel;
    logic [15:0] hb_timing_pair_sel;
    logic [NUM_FET-1:0] vds_fault_status;
    logic [NUM_HB-1:0] latched_off;
    logic [1:0] en_sync;
    logic [NUM_FET-1:0] over_meta;
    logic [NUM_FET-1:0] over_sync;
    logic [NUM_FET-1:0] prev_on;
    logic [NUM_FET-1:0] pre_short;
    logic [NUM_FET-1:0][BLANK_W-1:0] blank_cnt;
    logic [NUM_FET-1:0][FILT_W-1:0] filt_cnt;
    logic [DATA_W-1:0] rdata;
  } dsfm_state_t;

  localparam dsfm_state_t ST_RST = '{
    bridge_passive_sel: PASSIVE_RST,
    vds_filter_time: FILT_RST,
    static_discharge_current_cfg: DIS_RST,
    thr: THR_RST,
    drain_ref: REF_RST,
    blank_time_sel: BLANK_RST,
    hb_timing_pair_sel: PAIR_RST,
    default: '0
  };

  dsfm_state_t state_reg;
  dsfm_state_t state_next;
  logic active;
  logic [NUM_FET-1:0] gate_on;
  logic [NUM_FET-1:0] fault;
  logic [NUM_HB-1:0] hb_fault;
  logic [FILT_W-1:0] filt_cyc;

  // bridge active only with the pin high and passive mode off
  assign active = state_reg.en_sync[1] & ~state_reg.bridge_passive_sel;
  // a latched bridge keeps both gates off regardless of requests
  assign gate_on = {ls_on_req_in, hs_on_req_in}
                   & {NUM_FET{active}}
                   & ~{state_reg.latched_off, state_reg.latched_off};
  assign filt_cyc = FILT_W'(ns2cyc(FILT_NS[state_reg.vds_filter_time]));

  // next state: register port, synchronisers, per-FET timers, fault latch
  always_comb begin
    logic [2:0] pair;
    logic [2:0] code;
    logic [FILT_W-1:0] tgt;
    logic [NUM_FET-1:0] clr;
    pair = '0;
    code = '0;
    tgt = '0;
    clr = '0;
    state_next = state_reg;
    fault = '0;

    // two flops on every asynchronous input before any logic reads it
    state_next.en_sync = {state_reg.en_sync[0], enable_in};
    state_next.over_meta = {ls_over_in, hs_over_in};
    state_next.over_sync = state_reg.over_meta;
    state_next.prev_on = gate_on;

    for (int i = 0; i < NUM_FET; i++) begin
      pair = {1'b0, state_reg.hb_timing_pair_sel[2*(i%NUM_HB) +: 2]};
      code = state_reg.blank_time_sel[3*pair +: 3];
      tgt = state_reg.pre_short[i] ? FILT_W'(2 * filt_cyc) : filt_cyc;
      if (!gate_on[i]) begin
        // FET off: nothing to watch, timers idle
        state_next.blank_cnt[i] = '0;
        state_next.filt_cnt[i] = '0;
        state_next.pre_short[i] = 1'b0;
      end else if (!state_reg.prev_on[i]) begin
        // turn-on seen the cycle the command is decoded
        state_next.blank_cnt[i] = BLANK_W'(ns2cyc(BLANK_NS[code]));
        state_next.filt_cnt[i] = '0;
        state_next.pre_short[i] = 1'b0;
      end else if (state_reg.blank_cnt[i] != '0) begin
        // faults masked; the last blank sample tells whether a short
        // is already there; earlier samples still see the stale
        // synchroniser and the normal switching transient
        state_next.blank_cnt[i] = state_reg.blank_cnt[i] - 1'b1;
        state_next.pre_short[i] = state_reg.over_sync[i];
      end else if (state_reg.over_sync[i]) begin
        // must stay over threshold for longer than the filter time
        if (state_reg.filt_cnt[i] >= tgt) begin
          fault[i] = 1'b1;
        end else begin
          state_next.filt_cnt[i] = state_reg.filt_cnt[i] + 1'b1;
        end
      end else begin
        state_next.filt_cnt[i] = '0;
      end
    end

    // write strobe: configuration and write-one-to-clear status
    if (bus_in.wr) begin
      case (bus_in.addr)
        ADDR_GCTRL: begin
          state_next.bridge_passive_sel = bus_in.wdata[GC_PASSIVE_BIT];
          state_next.vds_filter_time = bus_in.wdata[GC_FILT_LSB +: 2];
          state_next.static_discharge_current_cfg =
            bus_in.wdata[GC_DIS_LSB +: 5];
        end
        ADDR_THR: state_next.thr = bus_in.wdata[23:0];
        ADDR_REF: state_next.drain_ref = bus_in.wdata[7:0];
        ADDR_BLANK: state_next.blank_time_sel = bus_in.wdata[11:0];
        ADDR_PAIR: state_next.hb_timing_pair_sel = bus_in.wdata[15:0];
        ADDR_STAT: clr = bus_in.wdata[NUM_FET-1:0];
        default: clr = '0;
      endcase
    end

    // a fault in the clearing cycle wins over the clear
    state_next.vds_fault_status =
      (state_reg.vds_fault_status & ~clr) | fault;
    hb_fault = fault[NUM_HB-1:0] | fault[NUM_FET-1:NUM_HB];
    // stays off while either status bit of the bridge is still set
    state_next.latched_off = hb_fault
      | (state_reg.latched_off
         & (state_next.vds_fault_status[NUM_HB-1:0]
            | state_next.vds_fault_status[NUM_FET-1:NUM_HB]));

    // read strobe: data stand in the following cycle only
    state_next.rdata = '0;
    if (bus_in.rd) begin
      case (bus_in.addr)
        ADDR_GCTRL: begin
          state_next.rdata[GC_PASSIVE_BIT] = state_reg.bridge_passive_sel;
          state_next.rdata[GC_FILT_LSB +: 2] = state_reg.vds_filter_time;
          state_next.rdata[GC_DIS_LSB +: 5] =
            state_reg.static_discharge_current_cfg;
        end
        ADDR_THR: state_next.rdata[23:0] = state_reg.thr;
        ADDR_REF: state_next.rdata[7:0] = state_reg.drain_ref;
        ADDR_BLANK: state_next.rdata[11:0] = state_reg.blank_time_sel;
        ADDR_PAIR: state_next.rdata[15:0] = state_reg.hb_timing_pair_sel;
        ADDR_STAT:
          state_next.rdata[NUM_FET-1:0] = state_reg.vds_fault_status;
        ADDR_GSTAT: state_next.rdata[GSTAT_GLOBAL_VDS_ERROR_BIT] =
          |state_reg.vds_fault_status;
        default: state_next.rdata = '0;
      endcase
    end
  end

  // single state register, constant under reset
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // comparator steering: drain reference picks drain sense or shunt input
  // one for the high side; low side always compares node to its source
  assign cmp_cfg_out.threshold = state_reg.thr;
  assign cmp_cfg_out.drain_ref_sel = state_reg.drain_ref;

  // gate drive; a tripped bridge is discharged as if statically driven
  assign gate_out.hs_on = gate_on[NUM_HB-1:0];
  assign gate_out.ls_on = gate_on[NUM_FET-1:NUM_HB];
  assign gate_out.static_discharge = state_reg.latched_off;
  assign gate_out.discharge_current =
    state_reg.static_discharge_current_cfg;
  assign global_vds_error_out = |state_reg.vds_fault_status;
  assign bus_rdata_out = state_reg.rdata;

endmodule

`default_nettype wire

// ===== dsfm_fet_model.sv
/* far-side fet and comparator model, one per gate side.
   assumes the bench chooses which fets are shorted. */
`default_nettype none
module dsfm_fet_model (
  input wire logic clk_in,
  input wire logic [7:0] gate_in,
  input wire logic [7:0] short_in,
  output logic [7:0] over_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip_reg = 1'b0;
  // an off fet gives a restless comparator, never a quiet zero
  always_ff @(posedge clk_in) begin
    flip_reg <= ~flip_reg;
  end
  // a shorted fet that is on crosses its threshold
  assign over_out = (gate_in & short_in) | (~gate_in & {8{flip_reg}});
endmodule
`default_nettype wire

// ===== dsfm_checker.sv
/* port assertions of the drain-source fault monitor.
   assumes one clock domain; attached by the bind at the foot. */
`default_nettype none
module dsfm_checker
  import dsfm_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic [NUM_HB-1:0] hs_on_req_in,
  input wire logic [NUM_HB-1:0] ls_on_req_in,
  input wire dsfm_bus_req_t bus_in,
  input wire logic [DATA_W-1:0] bus_rdata_out,
  input wire dsfm_gate_t gate_out,
  input wire logic global_vds_error_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  logic st_wr;
  logic [11:0] on_cnt_reg;
  assign st_wr = bus_in.wr && bus_in.addr == ADDR_STAT;
  // on-time of bridge 0 high gate; resets when the gate drops
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) on_cnt_reg <= 12'h000;
    else on_cnt_reg <= gate_out.hs_on[0] ? on_cnt_reg + 12'h001 : 12'h000;
  end
  hs_latch_off_a: assert property (
    (gate_out.hs_on & gate_out.static_discharge) == 0)
    else $error("high gate on while latched");
  ls_latch_off_a: assert property (
    (gate_out.ls_on & gate_out.static_discharge) == 0)
    else $error("low gate on while latched");
  gate_needs_req_a: assert property (
    (gate_out.hs_on & ~hs_on_req_in) == 0
    && (gate_out.ls_on & ~ls_on_req_in) == 0)
    else $error("gate on without request");
  gate_enable_a: assert property (
    !enable_in [*3] |-> gate_out.hs_on == 0 && gate_out.ls_on == 0)
    else $error("gate on with enable low");
  blank_mask_a: assert property (
    $rose(gate_out.static_discharge[0]) |-> on_cnt_reg >= 12'd110)
    else $error("trip inside blank plus filter");
  latch_clear_a: assert property (
    ($past(gate_out.static_discharge) & ~gate_out.static_discharge) != 0
    |-> $past(st_wr) || $past(st_wr, 2))
    else $error("latch dropped without status write");
  err_clear_a: assert property (
    $fell(global_vds_error_out) |-> $past(st_wr) || $past(st_wr, 2))
    else $error("error dropped without status write");
  err_latch_a: assert property (
    $rose(global_vds_error_out) |-> gate_out.static_discharge != 0)
    else $error("error without latched bridge");
  rdata_idle_a: assert property (
    !$past(bus_in.rd) |-> bus_rdata_out == 0)
    else $error("read data outside its cycle");
endmodule
bind dsfm_monitor dsfm_checker i_chk (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .enable_in(enable_in),
  .hs_on_req_in(hs_on_req_in), .ls_on_req_in(ls_on_req_in),
  .bus_in(bus_in), .bus_rdata_out(bus_rdata_out), .gate_out(gate_out),
  .global_vds_error_out(global_vds_error_out));
`default_nettype wire

// ===== tb_drain_source_fault_monitor.sv
/* self-checking bench of the drain-source fault monitor.
   assumes the fet model and checker files are compiled first. */
`default_nettype none
module tb_drain_source_fault_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import dsfm_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic enable_in = 1'b1;
  logic [7:0] hs_req = 8'h00, ls_req = 8'h00, hs_sh = 8'h00, ls_sh = 8'h00;
  logic [7:0] hs_ov, ls_ov;
  logic [31:0] rdata, d;
  logic err;
  dsfm_bus_req_t bus = '0;
  dsfm_cmp_cfg_t cfg;
  dsfm_gate_t gate;
  int n_mismatch = 0, checked = 0, n;
  always #5 clk_in = ~clk_in;
  dsfm_monitor i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .enable_in(enable_in), .hs_on_req_in(hs_req), .ls_on_req_in(ls_req),
    .hs_over_in(hs_ov), .ls_over_in(ls_ov), .bus_in(bus),
    .bus_rdata_out(rdata), .cmp_cfg_out(cfg), .gate_out(gate),
    .global_vds_error_out(err));
  dsfm_fet_model i_hs (.clk_in(clk_in), .gate_in(gate.hs_on),
    .short_in(hs_sh), .over_out(hs_ov));
  dsfm_fet_model i_ls (.clk_in(clk_in), .gate_in(gate.ls_on),
    .short_in(ls_sh), .over_out(ls_ov));
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in) bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clk_in) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_in) bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  // counts edges until bridge b latches; a lapse ends the run
  task automatic trip(input int b, input int lim);
    for (n = 0; n < lim && gate.static_discharge[b] !== 1'b1; n++) begin
      @(posedge clk_in);
      #1;
    end
    if (n == lim) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic t_regs();
    rd(ADDR_THR);
    chk(d, {8'h00, THR_RST});
    rd(ADDR_BLANK);
    chk(d, {20'h0, BLANK_RST});
    rd(ADDR_GCTRL);
    chk(d, 32'h0);
    rd(8'h40);
    chk(d, 32'h0);
    wr(ADDR_THR, {8'h00, {8{3'h2}}});
    wr(ADDR_REF, 32'hA5);
    #1 chk(cfg.threshold, {8{3'h2}});
    chk(cfg.drain_ref_sel, 8'hA5);
  endtask
  // a glitch shorter than the filter, then a lasting short
  task automatic t_fault();
    wr(ADDR_GCTRL, 32'hA8);
    @(posedge clk_in) hs_req[0] <= 1'b1;
    cyc(210);
    hs_sh[0] <= 1'b1;
    cyc(40);
    hs_sh[0] <= 1'b0;
    cyc(3);
    hs_sh[0] <= 1'b1;
    cyc(40);
    #1 chk(gate.static_discharge[0], 1'b0);
    trip(0, 30);
    chk(n <= 20, 1'b1);
    cyc(2);
    #1 chk(gate.hs_on[0], 1'b0);
    chk(gate.discharge_current, 5'h15);
    chk(err, 1'b1);
    rd(ADDR_STAT);
    chk(d, 32'h1);
    @(posedge clk_in) hs_sh[0] <= 1'b0;
    cyc(5);
    #1 chk(gate.hs_on[0], 1'b0);
    wr(ADDR_STAT, 32'h1);
    cyc(2);
    #1 chk(gate.hs_on[0], 1'b1);
    @(posedge clk_in) hs_req[0] <= 1'b0;
  endtask
  // short present before turn-on, pair 1 with the shortest blank
  task automatic t_pre();
    wr(ADDR_BLANK, 32'h904);
    wr(ADDR_PAIR, 32'h4);
    @(posedge clk_in) ls_sh[1] <= 1'b1;
    @(posedge clk_in) ls_req[1] <= 1'b1;
    trip(1, 300);
    chk(n >= 160 && n <= 172, 1'b1);
    rd(ADDR_STAT);
    chk(d, 32'h200);
    @(posedge clk_in) ls_sh[1] <= 1'b0;
    wr(ADDR_STAT, 32'h200);
    cyc(2);
    #1 chk(gate.ls_on[1], 1'b1);
    rd(ADDR_GSTAT);
    chk(d, 32'h0);
    @(posedge clk_in) ls_req[1] <= 1'b0;
  endtask
  task automatic t_passive();
    wr(ADDR_GCTRL, 32'hA9);
    @(posedge clk_in) hs_req[2] <= 1'b1;
    cyc(2);
    #1 chk(gate.hs_on[2], 1'b0);
    wr(ADDR_GCTRL, 32'hA8);
    cyc(1);
    #1 chk(gate.hs_on[2], 1'b1);
    @(posedge clk_in) enable_in <= 1'b0;
    cyc(3);
    #1 chk(gate.hs_on[2], 1'b0);
  endtask
  initial begin
    cyc(12);
    sys_rst_in <= 1'b0;
    t_regs();
    t_fault();
    t_pre();
    t_passive();
    summarize();
  end
endmodule
`default_nettype wire
